/* File: adcr_host.sv */
// Design decision made here: register access over AXI4-Lite.
`default_nettype none
module adcr_host (
    input wire logic clock,
    input wire logic rst_b,
    adcr_link_if.host link,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import adcr_pkg::*;

    // ======================================================
    // state
    typedef struct packed {
        adcr_hst_state_t st; // frame sequencer
        logic [3:0] tmr; // half-period countdown
        logic [5:0] edg; // clock edges made this frame
        logic sclk; // driven serial clock
        logic cs_b; // driven frame select
        logic [23:0] tx; // outgoing frame
        logic [1:0] sdo0_s; // [0] first sync stage
        logic [1:0] sdo1_s;
        logic [3:0] rxn; // read bits captured
        logic [7:0] rx; // first byte of the read lanes
        logic [7:0] last; // byte from the last frame
        logic [23:0] frame; // last frame written
        logic [2:0] mode; // {dual, cpol, cpha}
        logic aw_f; // write address held
        logic [7:0] awa;
        logic w_f; // write data held
        logic [31:0] wd;
        logic [3:0] ws;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
    } adcr_hst_st_t;

    adcr_hst_st_t s_q;
    adcr_hst_st_t s_d;

    logic smp_lvl;
    logic busy;

    // level after an edge that makes it a sample edge
    assign smp_lvl = ~(s_q.mode[1] ^ s_q.mode[0]);
    assign busy = s_q.st != H_IDLE;

    // ======================================================
    // next state: bus slave plus frame sequencer
    always_comb begin
        logic [23:0] nf;
        logic go;
        nf = s_q.frame;
        go = 1'b0;
        s_d = s_q;
        s_d.sdo0_s = {s_q.sdo0_s[0], link.sdo0};
        s_d.sdo1_s = {s_q.sdo1_s[0], link.sdo1};
        // accept address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_f = 1'b1;
            s_d.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_f = 1'b1;
            s_d.wd = s_axi_wdata;
            s_d.ws = s_axi_wstrb;
        end
        if (s_q.bv && s_axi_bready) begin
            s_d.bv = 1'b0;
        end
        if (s_q.aw_f && s_q.w_f && !s_q.bv) begin
            s_d.aw_f = 1'b0;
            s_d.w_f = 1'b0;
            s_d.bv = 1'b1;
            s_d.br = RESP_OK;
            if (s_q.awa == AXI_FRAME) begin
                // a frame write while busy is dropped
                if (!busy) begin
                    for (int b = 0; b < 3; b++) begin
                        if (s_q.ws[b]) begin
                            nf[8*b +: 8] = s_q.wd[8*b +: 8];
                        end
                    end
                    go = 1'b1;
                end
            end else if (s_q.awa == AXI_MODE) begin
                if (s_q.ws[0]) begin
                    s_d.mode = s_q.wd[2:0];
                end
            end else if (s_q.awa != AXI_STAT) begin
                s_d.br = RESP_SLV;
            end
        end
        if (s_q.rv && s_axi_rready) begin
            s_d.rv = 1'b0;
        end else if (s_axi_arvalid && !s_q.rv) begin
            s_d.rv = 1'b1;
            s_d.rr = RESP_OK;
            case (s_axi_araddr)
                AXI_FRAME: s_d.rd = {8'h00, s_q.frame};
                AXI_STAT: s_d.rd = {16'h0000, s_q.last, 7'h00, busy};
                AXI_MODE: s_d.rd = {29'h0, s_q.mode};
                default: begin
                    s_d.rd = 32'h0000_0000;
                    s_d.rr = RESP_SLV;
                end
            endcase
        end
        // frame sequencer
        unique case (s_q.st)
            H_IDLE: begin
                // clock idles at the selected polarity
                s_d.sclk = s_q.mode[1];
                s_d.cs_b = 1'b1;
                if (go) begin
                    s_d.frame = nf;
                    s_d.tx = nf;
                    s_d.cs_b = 1'b0;
                    s_d.tmr = HALF_LD;
                    s_d.edg = 6'd0;
                    s_d.rxn = 4'd0;
                    s_d.st = H_RUN;
                end
            end
            H_RUN: begin
                if (s_q.tmr != 4'd0) begin
                    s_d.tmr = s_q.tmr - 4'd1;
                end else if (s_q.edg == EDGE_CNT) begin
                    s_d.tmr = HALF_LD;
                    s_d.st = H_TAIL;
                end else begin
                    s_d.sclk = ~s_q.sclk;
                    s_d.tmr = HALF_LD;
                    s_d.edg = s_q.edg + 6'd1;
                    if (~s_q.sclk == smp_lvl) begin
                        // capture the first byte only
                        if (s_q.rxn < 4'd8) begin
                            if (s_q.mode[MODE_DUAL]) begin
                                s_d.rx = {s_q.rx[5:0], s_q.sdo1_s[1],
                                          s_q.sdo0_s[1]};
                                s_d.rxn = s_q.rxn + 4'd2;
                            end else begin
                                s_d.rx = {s_q.rx[6:0], s_q.sdo0_s[1]};
                                s_d.rxn = s_q.rxn + 4'd1;
                            end
                        end
                    end else if (s_q.edg != 6'd0) begin
                        s_d.tx = {s_q.tx[22:0], 1'b0};
                    end
                end
            end
            H_TAIL: begin
                if (s_q.tmr != 4'd0) begin
                    s_d.tmr = s_q.tmr - 4'd1;
                end else begin
                    // select rise commits the command
                    s_d.cs_b = 1'b1;
                    s_d.last = s_q.rx;
                    s_d.tmr = HALF_LD;
                    s_d.st = H_GAP;
                end
            end
            H_GAP: begin
                if (s_q.tmr != 4'd0) begin
                    s_d.tmr = s_q.tmr - 4'd1;
                end else begin
                    s_d.st = H_IDLE;
                end
            end
        endcase
    end

    // ======================================================
    // registers
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_q <= '0;
            s_q.st <= H_IDLE;
            s_q.cs_b <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================
    // outputs
    assign link.sclk = s_q.sclk;
    assign link.cs_b = s_q.cs_b;
    assign link.sdi = s_q.tx[23];
    assign s_axi_awready = !s_q.aw_f && !s_q.bv;
    assign s_axi_wready = !s_q.w_f && !s_q.bv;
    assign s_axi_bvalid = s_q.bv;
    assign s_axi_bresp = s_q.br;
    assign s_axi_arready = !s_q.rv;
    assign s_axi_rvalid = s_q.rv;
    assign s_axi_rdata = s_q.rd;
    assign s_axi_rresp = s_q.rr;
endmodule
`default_nettype wire

/* File: adcr_pkg.sv */
`default_nettype none
// ==========================================================
// shared constants for both ends of the configuration link
package adcr_pkg;
    // register addresses carried in the 11-bit frame field
    localparam logic [10:0] ADR_KEY = 11'h000;
    localparam logic [10:0] ADR_PD = 11'h004;
    localparam logic [10:0] ADR_SDI = 11'h008;
    localparam logic [10:0] ADR_OC1 = 11'h00c;
    localparam logic [10:0] ADR_OC2 = 11'h00d;
    localparam logic [10:0] ADR_OC3 = 11'h00e;
    localparam logic [10:0] ADR_OC4 = 11'h00f;
    localparam logic [10:0] ADR_DCW = 11'h010;
    localparam logic [10:0] ADR_PAR = 11'h011;
    // storage slots, one per register
    localparam int NREG = 9;
    localparam logic [3:0] IDX_KEY = 4'h0;
    localparam logic [3:0] IDX_PD = 4'h1;
    localparam logic [3:0] IDX_SDI = 4'h2;
    localparam logic [3:0] IDX_OC1 = 4'h3;
    localparam logic [3:0] IDX_OC2 = 4'h4;
    localparam logic [3:0] IDX_OC3 = 4'h5;
    localparam logic [3:0] IDX_OC4 = 4'h6;
    localparam logic [3:0] IDX_DCW = 4'h7;
    localparam logic [3:0] IDX_PAR = 4'h8;
    localparam logic [3:0] IDX_NONE = 4'hf;
    // writable bits per register, reserved bits stay zero
    localparam logic [7:0] MSK_KEY = 8'hff;
    localparam logic [7:0] MSK_PD = 8'h1e;
    localparam logic [7:0] MSK_SDI = 8'h03;
    localparam logic [7:0] MSK_OC1 = 8'h77;
    localparam logic [7:0] MSK_OC2 = 8'h01;
    localparam logic [7:0] MSK_OC3 = 8'h00;
    localparam logic [7:0] MSK_OC4 = 8'h01;
    localparam logic [7:0] MSK_DCW = 8'hff;
    localparam logic [7:0] MSK_PAR = 8'hff;
    localparam logic [7:0] RST_VAL = 8'h00;
    localparam logic [7:0] UNLOCK_KEY = 8'haa;
    // field positions
    localparam int PD_HALF = 4;
    localparam int INTERNAL_REFERENCE_OFF = 3;
    localparam int PD_BUF = 2;
    localparam int PD_CONV = 1;
    localparam int OC1_HOSTLEN = 6;
    localparam int OC1_RALIGN = 5;
    localparam int OC1_BYTESPLIT = 4;
    localparam int OC1_LANES = 2;
    localparam logic [1:0] PROTO_SPI = 2'h0;
    localparam logic [1:0] PROTO_RETIME = 2'h3;
    // frame commands
    localparam logic [4:0] OP_WR = 5'h01;
    localparam logic [4:0] OP_RD = 5'h02;
    localparam logic [4:0] OP_SET = 5'h03;
    localparam logic [4:0] OP_CLR = 5'h04;
    localparam logic [4:0] FRAME_CNT = 5'd24;
    localparam logic [5:0] EDGE_CNT = 6'd48;
    // link timing
    localparam int CLK_NS = 100;
    localparam int SCLK_HALF_NS = 800;
    localparam int HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] HALF_LD = 4'(HALF_CYC - 1);
    // controller register map on its bus
    localparam logic [7:0] AXI_FRAME = 8'h00;
    localparam logic [7:0] AXI_STAT = 8'h04;
    localparam logic [7:0] AXI_MODE = 8'h08;
    localparam int MODE_DUAL = 2;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLV = 2'h2;
    // controller sequencer states
    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_RUN = 4'b0010,
        H_TAIL = 4'b0100,
        H_GAP = 4'b1000
    } adcr_hst_state_t;
endpackage
`default_nettype wire

/* File: adcr_link_if.sv */
`default_nettype none
// ==========================================================
// serial configuration link between controller and device
interface adcr_link_if;
    logic sclk; // serial clock from the controller
    logic cs_b; // frame select, active low
    logic sdi; // command bits toward the device
    logic sdo0; // read lane 0
    logic sdo1; // read lane 1, msb lane in dual mode
    modport dev (input sclk, input cs_b, input sdi,
                 output sdo0, output sdo1);
    modport host (output sclk, output cs_b, output sdi,
                  input sdo0, input sdo1);
endinterface
`default_nettype wire

/* File: adcr_dev.sv */
`default_nettype none
module adcr_dev (
    input wire logic clock,
    input wire logic rst_b,
    adcr_link_if.dev link,
    output logic half_ref_buffer_off,
    output logic internal_reference_off,
    output logic reference_buffer_off,
    output logic converter_power_off,
    output logic [1:0] input_clock_mode_field,
    output logic host_friendly_length_enable,
    output logic right_align,
    output logic dual_lane_bytewise_split,
    output logic output_lane_count,
    output logic [1:0] output_protocol_field,
    output logic output_rate_select,
    output logic status_pin_config,
    output logic [7:0] output_word_format,
    output logic [7:0] check_bit_config,
    output logic write_unlocked
);
    import adcr_pkg::*;

    // ======================================================
    // decode helpers
    // address to storage slot, unmapped gives IDX_NONE
    function automatic logic [3:0] reg_idx(input logic [10:0] a);
        case (a)
            ADR_KEY: reg_idx = IDX_KEY;
            ADR_PD: reg_idx = IDX_PD;
            ADR_SDI: reg_idx = IDX_SDI;
            ADR_OC1: reg_idx = IDX_OC1;
            ADR_OC2: reg_idx = IDX_OC2;
            ADR_OC3: reg_idx = IDX_OC3;
            ADR_OC4: reg_idx = IDX_OC4;
            ADR_DCW: reg_idx = IDX_DCW;
            ADR_PAR: reg_idx = IDX_PAR;
            default: reg_idx = IDX_NONE;
        endcase
    endfunction

    // writable bits; reserved bits can never become one
    function automatic logic [7:0] reg_msk(input logic [3:0] i);
        case (i)
            IDX_KEY: reg_msk = MSK_KEY;
            IDX_PD: reg_msk = MSK_PD;
            IDX_SDI: reg_msk = MSK_SDI;
            IDX_OC1: reg_msk = MSK_OC1;
            IDX_OC2: reg_msk = MSK_OC2;
            IDX_OC3: reg_msk = MSK_OC3;
            IDX_OC4: reg_msk = MSK_OC4;
            IDX_DCW: reg_msk = MSK_DCW;
            IDX_PAR: reg_msk = MSK_PAR;
            default: reg_msk = 8'h00;
        endcase
    endfunction

    // ======================================================
    // state
    typedef struct packed {
        logic [2:0] sclk_s; // [0] first sync stage, [2] last
        logic [2:0] cs_s; // same layout for frame select
        logic [1:0] sdi_s; // two-stage sync of command data
        logic [4:0] cnt; // bits sampled, saturates
        logic [23:0] sh; // incoming frame
        logic [7:0] tx; // outgoing read byte
        logic [7:0] rd; // byte queued for the next frame
        logic [NREG-1:0][7:0] regs; // register storage
    } adcr_dev_st_t;

    adcr_dev_st_t s_q;
    adcr_dev_st_t s_d;

    logic cpol;
    logic cpha;
    logic sclk_edge;
    logic smp_edge;
    logic cs_fall;
    logic cs_rise;
    logic in_frame;
    logic unlocked;
    logic dual;
    logic proto_ok;
    logic [4:0] op;
    logic [3:0] idx;
    logic [7:0] dat;
    logic [7:0] msk;
    logic [7:0] cur;
    logic [7:0] oc1;

    // ======================================================
    // combinational decode of the synchronised pins
    assign cpol = s_q.regs[IDX_SDI][1];
    assign cpha = s_q.regs[IDX_SDI][0];
    // only stages two and three feed edge logic
    assign sclk_edge = s_q.sclk_s[1] ^ s_q.sclk_s[2];
    // modes 00 and 11 sample rising, 01 and 10 falling
    assign smp_edge = sclk_edge && (s_q.sclk_s[1] == ~(cpol ^ cpha));
    assign cs_fall = !s_q.cs_s[1] && s_q.cs_s[2];
    assign cs_rise = s_q.cs_s[1] && !s_q.cs_s[2];
    assign in_frame = !s_q.cs_s[1];
    assign unlocked = s_q.regs[IDX_KEY] == UNLOCK_KEY;
    assign op = s_q.sh[23:19];
    assign idx = reg_idx(s_q.sh[18:8]);
    assign dat = s_q.sh[7:0];
    assign msk = reg_msk(idx);
    // unmapped slot never indexes the array
    assign cur = (idx == IDX_NONE) ? 8'h00 : s_q.regs[idx];
    assign oc1 = s_q.regs[IDX_OC1];
    assign dual = oc1[OC1_LANES];
    assign proto_ok = (oc1[1:0] == PROTO_SPI) ||
                      (oc1[1:0] == PROTO_RETIME);

    // ======================================================
    // next state
    always_comb begin
        s_d = s_q;
        // pins shift through the synchronisers every cycle
        s_d.sclk_s = {s_q.sclk_s[1:0], link.sclk};
        s_d.cs_s = {s_q.cs_s[1:0], link.cs_b};
        s_d.sdi_s = {s_q.sdi_s[0], link.sdi};
        if (cs_fall) begin
            // new frame: restart count, present queued byte
            s_d.cnt = 5'd0;
            s_d.tx = s_q.rd;
            s_d.rd = 8'h00;
        end else if (in_frame && smp_edge) begin
            s_d.sh = {s_q.sh[22:0], s_q.sdi_s[1]};
            if (s_q.cnt != 5'h1f) begin
                s_d.cnt = s_q.cnt + 5'd1;
            end
        end else if (in_frame && sclk_edge && s_q.cnt != 5'd0) begin
            // launch edge; skipped before first sample so
            // that clock phase 1 keeps the first bit
            s_d.tx = dual ? {s_q.tx[5:0], 2'b00}
                          : {s_q.tx[6:0], 1'b0};
        end else if (cs_rise) begin
            s_d.tx = 8'h00;
            // short or long frames are dropped whole
            if (s_q.cnt == FRAME_CNT) begin
                // key slot always open, others need the key
                if (idx != IDX_NONE &&
                    (idx == IDX_KEY || unlocked)) begin
                    // power bits land here, at the select rise
                    case (op)
                        OP_WR: begin
                            s_d.regs[idx] = dat & msk;
                        end
                        OP_SET: begin
                            s_d.regs[idx] = (cur | dat) & msk;
                        end
                        OP_CLR: begin
                            s_d.regs[idx] = cur & ~dat;
                        end
                        default: begin
                            // nop, read and reserved codes
                        end
                    endcase
                end
                // reads are not gated by the key
                if (op == OP_RD) begin
                    s_d.rd = cur;
                end
            end
        end
    end

    // ======================================================
    // registers; reset clears all storage to zero
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================
    // outputs from storage, plus the key compare and the gated read lanes
    assign half_ref_buffer_off = s_q.regs[IDX_PD][PD_HALF];
    assign internal_reference_off = s_q.regs[IDX_PD][INTERNAL_REFERENCE_OFF];
    assign reference_buffer_off = s_q.regs[IDX_PD][PD_BUF];
    // host must still wait the wake-up time after clearing
    assign converter_power_off = s_q.regs[IDX_PD][PD_CONV];
    assign input_clock_mode_field = s_q.regs[IDX_SDI][1:0];
    assign host_friendly_length_enable = oc1[OC1_HOSTLEN];
    assign right_align = oc1[OC1_RALIGN];
    assign dual_lane_bytewise_split = oc1[OC1_BYTESPLIT];
    assign output_lane_count = dual;
    assign output_protocol_field = oc1[1:0];
    assign output_rate_select = s_q.regs[IDX_OC2][0];
    assign status_pin_config = s_q.regs[IDX_OC4][0];
    assign output_word_format = s_q.regs[IDX_DCW];
    assign check_bit_config = s_q.regs[IDX_PAR];
    assign write_unlocked = unlocked;
    // unsupported protocol codes hold both lanes low
    assign link.sdo1 = proto_ok && dual && s_q.tx[7];
    assign link.sdo0 = proto_ok && (dual ? s_q.tx[6] : s_q.tx[7]);
endmodule
`default_nettype wire

/* File: adcr_link_assertions.sv */
`default_nettype none
// ====================================
// link checker, beside the shared interface
module adcr_link_assertions (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic cs_b,
    input wire logic sdo0,
    input wire logic sdo1,
    input wire logic half_ref_buffer_off,
    input wire logic internal_reference_off,
    input wire logic reference_buffer_off,
    input wire logic converter_power_off,
    input wire logic [1:0] input_clock_mode_field,
    input wire logic output_lane_count,
    input wire logic write_unlocked
);
    import adcr_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic [5:0] edge_cnt_q; // serial clock edges in this frame
    logic sclk_q; // last serial clock level
    // ====================================
    // edge counter, cleared between frames so idle level is moot
    always_ff @(posedge clock) begin
        sclk_q <= sclk;
        if (cs_b) edge_cnt_q <= '0;
        else if (sclk != sclk_q) edge_cnt_q <= edge_cnt_q + 6'h1;
    end
    property p_frame_edges;
        $rose(cs_b) |-> edge_cnt_q == EDGE_CNT;
    endproperty
    a_frame_edges: assert property (p_frame_edges)
        else $error("frame edge count wrong");
    property p_cs_gap;
        $rose(cs_b) |-> cs_b [*8];
    endproperty
    a_cs_gap: assert property (p_cs_gap)
        else $error("select gap too short");
    property p_lane;
        !output_lane_count |-> !sdo1;
    endproperty
    a_lane: assert property (p_lane)
        else $error("lane 1 active in single lane");
    property p_conv_frame;
        !cs_b |-> $stable(converter_power_off);
    endproperty
    a_conv_frame: assert property (p_conv_frame)
        else $error("converter power moved in frame");
    property p_ref_frame;
        !cs_b |-> $stable({internal_reference_off, reference_buffer_off,
            half_ref_buffer_off});
    endproperty
    a_ref_frame: assert property (p_ref_frame)
        else $error("reference power moved in frame");
    property p_mode_frame;
        !cs_b |-> $stable(input_clock_mode_field);
    endproperty
    a_mode_frame: assert property (p_mode_frame)
        else $error("clock mode moved in frame");
    property p_key_change;
        $changed(write_unlocked) |-> cs_b && $past(cs_b, 2);
    endproperty
    a_key_change: assert property (p_key_change)
        else $error("unlock moved in frame");
    // reset itself is the antecedent, so no disable here
    property p_reset;
        disable iff (1'b0) !rst_b |=> !converter_power_off &&
            !write_unlocked && !sdo0 && !sdo1 && cs_b && !sclk;
    endproperty
    a_reset: assert property (p_reset)
        else $error("state not cleared by reset");
    c_frame: cover property ($rose(cs_b));
    c_unlock: cover property ($rose(write_unlocked));
    c_conv_off: cover property ($rose(converter_power_off));
endmodule
`default_nettype wire

/* File: adcr_tb_top.sv */
`default_nettype none
module adcr_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import adcr_pkg::*;
    // ====================================
    // clock, reset, bus and observed levels
    logic clock = 1'b0, rst_b = 1'b0;
    logic [7:0] aw_addr = '0, ar_addr = '0;
    logic [31:0] w_data = '0, r_data;
    logic aw_v = 1'b0, w_v = 1'b0, b_rdy = 1'b0, ar_v = 1'b0, r_rdy = 1'b0;
    logic aw_r, w_r, b_v, ar_r, r_v, lanes, unl;
    logic [1:0] b_resp, r_resp, cmode;
    logic [3:0] pd; // power-off levels, same order as reg bits 4:1
    int err_count = 0, n_compared = 0;
    // rows: address, written byte, byte read back
    logic [26:0] rows [8] = '{{ADR_PD, 16'hfe1e}, {ADR_OC1, 16'hfb73},
        {ADR_OC2, 16'hff01}, {ADR_OC3, 16'hff00}, {ADR_OC4, 16'hff01},
        {ADR_DCW, 16'h5a5a}, {ADR_PAR, 16'ha5a5}, {11'h005, 16'hff00}};
    always #50 clock = ~clock;
    adcr_link_if adcr_link_if_i ();
    adcr_host adcr_host_i (.clock(clock), .rst_b(rst_b),
        .link(adcr_link_if_i), .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_v),
        .s_axi_awready(aw_r), .s_axi_wdata(w_data), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_resp),
        .s_axi_bvalid(b_v), .s_axi_bready(b_rdy), .s_axi_araddr(ar_addr),
        .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_data),
        .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_rdy));
    adcr_dev adcr_dev_i (.clock(clock), .rst_b(rst_b),
        .link(adcr_link_if_i), .half_ref_buffer_off(pd[3]),
        .internal_reference_off(pd[2]), .reference_buffer_off(pd[1]),
        .converter_power_off(pd[0]), .input_clock_mode_field(cmode),
        .host_friendly_length_enable(), .right_align(),
        .dual_lane_bytewise_split(), .output_lane_count(lanes),
        .output_protocol_field(), .output_rate_select(),
        .status_pin_config(), .output_word_format(), .check_bit_config(),
        .write_unlocked(unl));
    adcr_link_assertions adcr_link_assertions_i (.clock(clock),
        .rst_b(rst_b), .sclk(adcr_link_if_i.sclk), .cs_b(adcr_link_if_i.cs_b),
        .sdo0(adcr_link_if_i.sdo0), .sdo1(adcr_link_if_i.sdo1),
        .half_ref_buffer_off(pd[3]), .internal_reference_off(pd[2]),
        .reference_buffer_off(pd[1]), .converter_power_off(pd[0]),
        .input_clock_mode_field(cmode), .output_lane_count(lanes),
        .write_unlocked(unl));
    // ====================================
    // verdict, reached from the end or from a stuck wait
    task automatic finish_test;
        $display("errors %0d of %0d compared", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            err_count++;
            $display("FAIL %0t saw %h want %h", $time, s, e);
        end
    endtask
    task automatic hang(input logic ok);
        if (ok !== 1'b1) begin
            err_count++;
            $display("FAIL %0t no answer", $time);
            finish_test();
        end
    endtask
    // handshakes judged at the negedge so no edge race
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
        output logic [1:0] rsp);
        int n;
        logic aw, w, b;
        n = 0;
        b = 0;
        aw_addr <= a;
        w_data <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_rdy <= 1'b1;
        while (!b && n < 100) begin
            @(negedge clock);
            aw = aw_v && aw_r;
            w = w_v && w_r;
            b = b_v;
            rsp = b_resp;
            @(posedge clock);
            if (aw) aw_v <= 1'b0;
            if (w) w_v <= 1'b0;
            n++;
        end
        hang(b);
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] rsp);
        int n;
        logic ar, r;
        n = 0;
        r = 0;
        ar_addr <= a;
        ar_v <= 1'b1;
        r_rdy <= 1'b1;
        while (!r && n < 100) begin
            @(negedge clock);
            ar = ar_v && ar_r;
            r = r_v;
            d = r_data;
            rsp = r_resp;
            @(posedge clock);
            if (ar) ar_v <= 1'b0;
            n++;
        end
        hang(r);
    endtask
    // one frame, then poll busy until the frame is done
    task automatic cmd(input logic [4:0] op, input logic [10:0] a,
        input logic [7:0] d);
        logic [31:0] s;
        logic [1:0] rsp;
        int n;
        axi_wr(AXI_FRAME, {8'h00, op, a, d}, rsp);
        s = 32'h1;
        for (n = 0; n < 300 && s[0]; n++) axi_rd(AXI_STAT, s, rsp);
        hang(!s[0]);
    endtask
    // read answer only shows in the following frame
    task automatic rd(input logic [10:0] a, output logic [7:0] v);
        logic [31:0] s;
        logic [1:0] rsp;
        cmd(OP_RD, a, 8'h00);
        cmd(5'h00, 11'h000, 8'h00);
        axi_rd(AXI_STAT, s, rsp);
        v = s[15:8];
    endtask
    // ====================================
    // main sequence
    initial begin
        logic [7:0] v;
        logic [31:0] s;
        logic [1:0] rsp;
        int m;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        chk({3'h0, unl, pd}, 8'h00);
        cmd(OP_WR, ADR_PD, 8'h1e);
        rd(ADR_PD, v);
        chk(v, 8'h00);
        chk({4'h0, pd}, 8'h00);
        cmd(OP_WR, ADR_KEY, UNLOCK_KEY);
        chk({7'h0, unl}, 8'h01);
        foreach (rows[i]) begin
            cmd(OP_WR, rows[i][26:16], rows[i][15:8]);
            rd(rows[i][26:16], v);
            chk(v, rows[i][7:0]);
        end
        chk({3'h0, lanes, pd}, 8'h0f);
        cmd(OP_CLR, ADR_PD, 8'h12);
        chk({4'h0, pd}, 8'h06);
        cmd(OP_SET, ADR_PD, 8'h02);
        chk({4'h0, pd}, 8'h07);
        for (m = 0; m < 4; m++) begin
            cmd(OP_WR, ADR_SDI, 8'(m));
            chk({6'h0, cmode}, 8'(m));
            axi_wr(AXI_MODE, 32'(m), rsp);
            rd(ADR_SDI, v);
            chk(v, 8'(m));
            cmd(OP_WR, ADR_SDI, 8'h00);
            axi_wr(AXI_MODE, 32'h0, rsp);
        end
        // protocol 01 mutes both lanes, then a dual lane readback
        cmd(OP_WR, ADR_OC1, 8'h05);
        rd(ADR_DCW, v);
        chk(v, 8'h00);
        cmd(OP_WR, ADR_OC1, 8'h07);
        axi_wr(AXI_MODE, 32'h4, rsp);
        rd(ADR_DCW, v);
        chk({7'h0, lanes}, 8'h01);
        chk(v, 8'h5a);
        cmd(OP_WR, ADR_KEY, 8'h55);
        cmd(OP_CLR, ADR_PD, 8'hfe);
        chk({3'h0, unl, pd}, 8'h07);
        axi_rd(8'h0c, s, rsp);
        chk({6'h0, rsp}, {6'h0, RESP_SLV});
        finish_test();
    end
endmodule
`default_nettype wire
